//--- verilog/rcls_pkg.sv
// Package with register map, field layout and encodings of the setup state block
package rcls_pkg;
  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_SETUP_WORD = 8'h00;
  localparam logic [7:0] OFF_RASTER_CFG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  // ****************************************************************
  // Setup word field positions
  // ****************************************************************
  localparam int SMOOTH_BIT = 31;
  localparam int CULL_HI = 30;
  localparam int CULL_LO = 29;
  localparam int RSVD_BIT = 28;
  localparam int WIDTH_HI = 27;
  localparam int WIDTH_LO = 18;
  localparam int WIDTH_W = 10;
  // Raster config fields
  localparam int WINDING_BIT = 0;
  localparam int MSMODE_LO = 8;
  localparam int MSMODE_HI = 9;
  // ****************************************************************
  // Reset values and responses
  // ****************************************************************
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    cull_all_triangles = 2'h0,
    cull_no_triangles = 2'h1,
    cull_front_facing = 2'h2,
    cull_back_facing = 2'h3
  } rcls_cull_e;
  localparam logic front_is_clockwise = 1'h0;
  localparam logic front_is_counterclockwise = 1'h1;
  // Multisample modes 2h and 3h select multisample_raster_on
  localparam int MS_ON_BIT = 1;
  // Primitive kinds
  localparam logic [1:0] PRIM_POINT = 2'h0;
  localparam logic [1:0] PRIM_LINE = 2'h1;
  localparam logic [1:0] PRIM_TRIANGLE = 2'h2;
  localparam logic [1:0] PRIM_RECT = 2'h3;
endpackage

//--- verilog/rcls_cull_decide.sv
// Orientation culling decision for one primitive
`timescale 1ns/1ps
module rcls_cull_decide (
  // Primitive
  input wire logic [1:0] prim_kind,
  input wire logic screen_cw,
  // State
  input wire logic [1:0] cull_mode,
  input wire logic front_winding,
  // Result
  output logic discard
);
  logic front;
  always_comb begin
    // Front when screen order matches the winding setting
    front = (front_winding == rcls_pkg::front_is_clockwise) ? screen_cw : !screen_cw;
    discard = 1'b0;
    if (prim_kind == rcls_pkg::PRIM_TRIANGLE) begin
      case (cull_mode)
        rcls_pkg::cull_all_triangles: discard = 1'b1;
        rcls_pkg::cull_no_triangles: discard = 1'b0;
        rcls_pkg::cull_front_facing: discard = front;
        rcls_pkg::cull_back_facing: discard = !front;
        default: discard = 1'b0;
      endcase
    end
  end
endmodule

//--- verilog/rcls_setup.sv
// Setup state word holder with AXI4-Lite access, culling and line control
`timescale 1ns/1ps
// Contract
// - Bit 31 set enables alpha-based antialiasing of lines.
// - Smoothing is ignored while a multisample-on raster mode is selected.
// - Cull field 30:29: 0 all, 1 none, 2 front, 3 back discarded.
// - Culling applies to triangles only; others always pass.
// - Facing is decided from the front winding setting.
// - Line width is bits 27:18, unsigned 3.7 fixed point.
// - Zero width draws one-pixel, non-antialiased lines.
// - Zero width overrides smoothing; stored enable stays unchanged.
// - Zero-width lines use grid intersection quantization.
// - Winding 0 means clockwise front, 1 counter-clockwise front.
module rcls_setup (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Primitive in
  input wire logic prim_valid,
  input wire logic [1:0] prim_kind,
  input wire logic prim_screen_cw,
  // Primitive out to rasterizer
  output logic out_valid,
  output logic [1:0] out_kind,
  output logic out_discard,
  output logic out_smooth,
  output logic [rcls_pkg::WIDTH_W-1:0] out_line_width,
  output logic out_thin_line,
  output logic out_grid_quant
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] setup_word;
    logic [31:0] raster_cfg;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] prim_count;
    logic [31:0] cull_count;
    logic o_valid;
    logic [1:0] o_kind;
    logic o_discard;
    logic o_smooth;
    logic [rcls_pkg::WIDTH_W-1:0] o_width;
    logic o_thin;
  } rcls_state_s;

  rcls_state_s state_reg;
  rcls_state_s state_next;
  logic discard;
  logic [rcls_pkg::WIDTH_W-1:0] line_width;
  logic ms_on;
  logic zero_width;
  logic smooth_eff;
  logic do_write;

  // ****************************************************************
  // Culling
  // ****************************************************************
  rcls_cull_decide u_cull (
    .prim_kind(prim_kind),
    .screen_cw(prim_screen_cw),
    .cull_mode(state_reg.setup_word[rcls_pkg::CULL_HI:rcls_pkg::CULL_LO]),
    .front_winding(state_reg.raster_cfg[rcls_pkg::WINDING_BIT]),
    .discard(discard)
  );

  // ****************************************************************
  // Line controls
  // ****************************************************************
  always_comb begin
    line_width = state_reg.setup_word[rcls_pkg::WIDTH_HI:rcls_pkg::WIDTH_LO];
    ms_on = state_reg.raster_cfg[rcls_pkg::MSMODE_LO + rcls_pkg::MS_ON_BIT];
    zero_width = (line_width == '0);
    // Stored enable untouched; only its effect is masked
    smooth_eff = state_reg.setup_word[rcls_pkg::SMOOTH_BIT] && !ms_on && !zero_width;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    do_write = 1'b0;
    if (s_axi_awvalid && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_held) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
      do_write = 1'b1;
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = rcls_pkg::RESP_OKAY;
      case (state_reg.aw_addr)
        rcls_pkg::OFF_SETUP_WORD: begin
          for (int i = 0; i < 4; i++) begin
            if (state_reg.w_strb[i]) begin
              state_next.setup_word[i*8 +: 8] = state_reg.w_data[i*8 +: 8];
            end
          end
        end
        rcls_pkg::OFF_RASTER_CFG: begin
          for (int i = 0; i < 2; i++) begin
            if (state_reg.w_strb[i]) begin
              state_next.raster_cfg[i*8 +: 8] = state_reg.w_data[i*8 +: 8];
            end
          end
        end
        rcls_pkg::OFF_STATUS: begin
          state_next.prim_count = '0;
          state_next.cull_count = '0;
        end
        default: state_next.bresp = rcls_pkg::RESP_SLVERR;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = rcls_pkg::RESP_OKAY;
      case (s_axi_araddr)
        rcls_pkg::OFF_SETUP_WORD: state_next.rdata = state_reg.setup_word;
        rcls_pkg::OFF_RASTER_CFG: begin
          state_next.rdata = {16'h0000, state_reg.raster_cfg[15:0]};
        end
        rcls_pkg::OFF_STATUS: state_next.rdata = {state_reg.cull_count[15:0],
                                                  state_reg.prim_count[15:0]};
        default: begin
          state_next.rdata = 32'h0000_0000;
          state_next.rresp = rcls_pkg::RESP_SLVERR;
        end
      endcase
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // Primitive pipeline stage
    state_next.o_valid = prim_valid;
    if (prim_valid) begin
      state_next.o_kind = prim_kind;
      state_next.o_discard = discard;
      state_next.o_smooth = smooth_eff && (prim_kind == rcls_pkg::PRIM_LINE);
      state_next.o_width = line_width;
      state_next.o_thin = zero_width;
      // A status write drops a count taken in the same cycle
      if (!(do_write && state_reg.aw_addr == rcls_pkg::OFF_STATUS)) begin
        state_next.prim_count = state_reg.prim_count + 32'h0000_0001;
        if (discard) begin
          state_next.cull_count = state_reg.cull_count + 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.setup_word <= rcls_pkg::SETUP_RESET;
      state_reg.raster_cfg <= rcls_pkg::CFG_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = !state_reg.aw_held;
  assign s_axi_wready = !state_reg.w_held;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign out_valid = state_reg.o_valid;
  assign out_kind = state_reg.o_kind;
  assign out_discard = state_reg.o_discard;
  assign out_smooth = state_reg.o_smooth;
  assign out_line_width = state_reg.o_width;
  assign out_thin_line = state_reg.o_thin;
  assign out_grid_quant = state_reg.o_thin;
endmodule

//--- test/rcls_setup_asserts.sv
// Checker of the setup block ports
`timescale 1ns/1ps
module rcls_setup_asserts (
  // Clock, reset and bus
  input wire logic clock,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Primitives
  input wire logic prim_valid,
  input wire logic [1:0] prim_kind,
  input wire logic out_valid,
  input wire logic [1:0] out_kind,
  input wire logic out_discard,
  input wire logic out_smooth,
  input wire logic [rcls_pkg::WIDTH_W-1:0] out_line_width,
  input wire logic out_thin_line,
  input wire logic out_grid_quant
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence s_out;
    prim_valid ##1 out_valid;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_pending;
    s_wr_taken ##1 !s_axi_bvalid;
  endsequence
  AST_WRITE_ANSWER: assert property (s_wr_pending |=> s_axi_bvalid)
    else $error("write response late");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_ONE_OUT: assert property (prim_valid |=> out_valid && out_kind == $past(prim_kind))
    else $error("primitive lost");
  AST_NO_CULL: assert property (s_out ##0 out_kind != rcls_pkg::PRIM_TRIANGLE |-> !out_discard)
    else $error("non-triangle culled");
  AST_SMOOTH_LINE: assert property (s_out ##0 out_kind != rcls_pkg::PRIM_LINE |-> !out_smooth)
    else $error("smoothing off a line");
  AST_THIN: assert property (s_out |-> out_thin_line == (out_line_width == '0))
    else $error("thin flag wrong");
  AST_THIN_SHARP: assert property (s_out ##0 out_thin_line |-> !out_smooth)
    else $error("thin line smoothed");
  AST_GRID: assert property (s_out |-> out_grid_quant == out_thin_line)
    else $error("grid flag wrong");
  AST_READ_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  AST_WRITE_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule
bind rcls_setup rcls_setup_asserts u_chk (.clock, .nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .prim_valid, .prim_kind, .out_valid, .out_kind,
  .out_discard, .out_smooth, .out_line_width, .out_thin_line, .out_grid_quant);

//--- test/rcls_cmd_model.sv
// Command streamer model offering primitives
`timescale 1ns/1ps
module rcls_cmd_model (
  // Clock
  input wire logic clock,
  // Primitive out
  output logic prim_valid,
  output logic [1:0] prim_kind,
  output logic prim_screen_cw
);
  initial begin
    prim_valid = 1'b0;
    prim_kind = 2'h0;
    prim_screen_cw = 1'b0;
  end
  // One primitive, fields inverted when idle
  task automatic send(input logic [1:0] k, input logic c);
    prim_valid <= 1'b1;
    prim_kind <= k;
    prim_screen_cw <= c;
    @(posedge clock);
    prim_valid <= 1'b0;
    prim_kind <= ~k;
    prim_screen_cw <= ~c;
  endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench of the setup block
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] ws = 4'hF;
  logic awr, wr, bv, arr, rv, pv, pc, ov, od, os, ot, og;
  logic [1:0] br, rr, pk, ok;
  logic [rcls_pkg::WIDTH_W-1:0] ow;
  int num_errors = 0;
  int checks_done = 0;
  always #20 clock = ~clock;
  rcls_cmd_model cmd (.clock, .prim_valid(pv), .prim_kind(pk), .prim_screen_cw(pc));
  rcls_setup uut (.clock, .nrst, .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ar),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .prim_valid(pv), .prim_kind(pk),
    .prim_screen_cw(pc), .out_valid(ov), .out_kind(ok), .out_discard(od), .out_smooth(os),
    .out_line_width(ow), .out_thin_line(ot), .out_grid_quant(og));
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic bad);
    int n;
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    tmo(n);
    chk({30'h0, br}, {30'h0, bad ? rcls_pkg::RESP_SLVERR : rcls_pkg::RESP_OKAY}, "bresp");
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic bad);
    int n;
    ar <= a;
    arv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    tmo(n);
    chk(rd, e, "read data");
    chk({30'h0, rr}, {30'h0, bad ? rcls_pkg::RESP_SLVERR : rcls_pkg::RESP_OKAY}, "rresp");
  endtask
  function automatic logic [31:0] word(input logic s, input logic [1:0] c, input logic r,
    input logic [9:0] w);
    return {s, c, r, w, 18'h0};
  endfunction
  task automatic prim(input logic [1:0] k, input logic c, input logic [2:0] e, input string m);
    cmd.send(k, c);
    @(posedge clock);
    chk({26'h0, ok, ov, od, os, ot}, {26'h0, k, 1'b1, e}, m);
  endtask
  task automatic t_reset();
    axr(rcls_pkg::OFF_SETUP_WORD, 32'h0, 1'b0);
    prim(rcls_pkg::PRIM_TRIANGLE, 1'b0, 3'b101, "reset cull");
    prim(rcls_pkg::PRIM_LINE, 1'b0, 3'b001, "reset line");
  endtask
  task automatic t_cull();
    logic fr;
    logic ds;
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 2; w++) begin
        axw(rcls_pkg::OFF_SETUP_WORD, word(1'b0, m[1:0], w[0] ^ m[0], 10'h080), 1'b0);
        axw(rcls_pkg::OFF_RASTER_CFG, {31'h0, w[0]}, 1'b0);
        for (int k = 0; k < 4; k++) begin
          for (int c = 0; c < 2; c++) begin
            fr = (c[0] == (w[0] == rcls_pkg::front_is_clockwise));
            ds = (k == rcls_pkg::PRIM_TRIANGLE) && (m == 0 || (m == 2 && fr) || (m == 3 && !fr));
            prim(k[1:0], c[0], {ds, 2'b00}, "cull");
          end
        end
      end
    end
  endtask
  task automatic t_smooth();
    axw(rcls_pkg::OFF_SETUP_WORD, word(1'b1, 2'h1, 1'b0, 10'h3FF), 1'b0);
    prim(rcls_pkg::PRIM_LINE, 1'b0, 3'b010, "smooth line");
    chk({22'h0, ow}, 32'h3FF, "width");
    prim(rcls_pkg::PRIM_POINT, 1'b0, 3'b000, "smooth point");
    axw(rcls_pkg::OFF_RASTER_CFG, 32'h200, 1'b0);
    prim(rcls_pkg::PRIM_LINE, 1'b1, 3'b000, "ms on");
    axw(rcls_pkg::OFF_RASTER_CFG, 32'h300, 1'b0);
    prim(rcls_pkg::PRIM_LINE, 1'b0, 3'b000, "ms on 3");
    axw(rcls_pkg::OFF_RASTER_CFG, 32'h100, 1'b0);
    prim(rcls_pkg::PRIM_LINE, 1'b1, 3'b010, "ms off");
    axw(rcls_pkg::OFF_SETUP_WORD, word(1'b1, 2'h1, 1'b0, 10'h000), 1'b0);
    prim(rcls_pkg::PRIM_LINE, 1'b0, 3'b001, "zero width");
    chk({31'h0, og}, 32'h1, "grid");
    axr(rcls_pkg::OFF_SETUP_WORD, word(1'b1, 2'h1, 1'b0, 10'h000), 1'b0);
  endtask
  task automatic t_bus();
    axr(8'h0C, 32'h0, 1'b1);
    axw(8'h0C, 32'hFFFF_FFFF, 1'b1);
    axw(rcls_pkg::OFF_SETUP_WORD, 32'h0, 1'b0);
    axw(rcls_pkg::OFF_STATUS, 32'h0, 1'b0);
    prim(rcls_pkg::PRIM_TRIANGLE, 1'b1, 3'b101, "count");
    axr(rcls_pkg::OFF_STATUS, 32'h0001_0001, 1'b0);
    ws <= 4'h1;
    axw(rcls_pkg::OFF_SETUP_WORD, 32'hFFFF_FFFF, 1'b0);
    ws <= 4'hF;
    axr(rcls_pkg::OFF_SETUP_WORD, 32'h0000_00FF, 1'b0);
    axw(rcls_pkg::OFF_RASTER_CFG, 32'hFFFF_FCFF, 1'b0);
    axr(rcls_pkg::OFF_RASTER_CFG, 32'h0000_FCFF, 1'b0);
  endtask
  task automatic t_rerst();
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    axr(rcls_pkg::OFF_RASTER_CFG, 32'h0, 1'b0);
    axr(rcls_pkg::OFF_STATUS, 32'h0, 1'b0);
    t_reset();
  endtask
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset();
    t_cull();
    t_smooth();
    t_rerst();
    t_bus();
    finish_test();
  end
endmodule
